// ===== pkg/tick_rate_pkg.sv
// Constants and types for the tick rate and dormant wake logic.
// Assumes a single 25 MHz core clock and software strobes synchronous to it.
//
// Operation
// - Dormant: wake each minute, sample receive line
// - Spacing receive line exits dormancy like abort
// - Only break or power-up reset ends dormancy
// - Dormant selects 3.0 V supply, option ignored
// - Exit clears hundredths, multiplier back to one
// - Exit restores every I/O direction and level
// - Dormant: all I/O lines undriven inputs
// - Hundredths advance every 10 ms always
// - Tick period is 10 ms over multiplier
// - Multiplier field to 255, exact divisors only
// - Valid multipliers 1 to 200, divisors set
// - Multipliers 64, 192 only other fast variants
// - Multiplier is one after every reset
// - Housekeeping interrupt raised on every tick while running
package tick_rate_pkg;

  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned BASE_PERIOD_US = 10000;
  localparam int unsigned MAX_MULT       = 200;
  localparam int unsigned SUB_CYCLES     =
    ((CLK_HZ / 1000000) * BASE_PERIOD_US) / MAX_MULT;
  localparam int unsigned WAKE_PERIOD_S  = 60;
  localparam int unsigned HUND_PER_S     = 100;
  localparam int unsigned WAKE_HUNDREDTHS = WAKE_PERIOD_S * HUND_PER_S;

  localparam logic [7:0]  RATE_RST  = 8'h01;
  localparam logic [7:0]  STEP_MAX  = 8'hC8;
  localparam logic [31:0] HUND_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DORMANT,
    ST_CHECK
  } power_state_e;

endpackage

// ===== src/mod_counter.sv
// Wrapping counter with clear and enable, wrap pulse at limit.
// Assumes limit is at least one; clear wins over enable.
`timescale 1ns/10ps
`default_nettype none
module mod_counter #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clr,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] limit,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  assign wrap  = en && !clr && (cnt_ff == limit - WIDTH'(1));
  assign count = cnt_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr) begin
      nxt_cnt = '0;
    end else if (wrap) begin
      nxt_cnt = '0;
    end else if (en) begin
      nxt_cnt = cnt_ff + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // mod_counter
`default_nettype wire

// ===== src/tick_rate_and_dormant_wake.sv
// Tick generator, hundredths counter and dormant state with minute wake.
// Assumes all inputs synchronous to core_clk; strobes are one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module tick_rate_and_dormant_wake #(
  parameter int unsigned   IO_LINES   = 16,
  parameter int unsigned   HUND_WIDTH = 32,
  parameter logic [10:0]   PRESCALE   = 11'(tick_rate_pkg::SUB_CYCLES),
  parameter logic [12:0]   WAKE_HUND  = 13'(tick_rate_pkg::WAKE_HUNDREDTHS)
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  rate_wr,
  input  wire logic [7:0]            rate_val,
  input  wire logic                  wait_restart,
  input  wire logic                  dormant_entry_command,
  input  wire logic                  low_voltage_option,
  input  wire logic                  rx_line,
  input  wire logic                  io_wr,
  input  wire logic [IO_LINES-1:0]   io_dir_val,
  input  wire logic [IO_LINES-1:0]   io_lvl_val,
  output logic                       hk_irq_ff,
  output logic [HUND_WIDTH-1:0]      hund_ff,
  output logic [7:0]                 rate_ff,
  output logic                       dormant_ff,
  output logic                       check_ff,
  output logic                       abort_ff,
  output logic                       supply_low_ff,
  output logic [IO_LINES-1:0]        gpio_o_ff,
  output logic [IO_LINES-1:0]        gpio_oe_ff
);

  tick_rate_pkg::power_state_e state_ff;
  tick_rate_pkg::power_state_e nxt_state;

  logic [7:0]            step_ff;
  logic [7:0]            nxt_step;
  logic [7:0]            nxt_rate;
  logic [HUND_WIDTH-1:0] nxt_hund;
  logic [IO_LINES-1:0]   io_dir_ff;
  logic [IO_LINES-1:0]   io_lvl_ff;
  logic [IO_LINES-1:0]   nxt_io_dir;
  logic [IO_LINES-1:0]   nxt_io_lvl;
  logic [IO_LINES-1:0]   nxt_gpio_o;
  logic [IO_LINES-1:0]   nxt_gpio_oe;
  logic                  nxt_hk_irq;
  logic                  nxt_dormant;
  logic                  nxt_check;
  logic                  nxt_abort;
  logic                  nxt_supply_low;

  logic                  sub_wrap;
  logic                  phase_wrap;
  logic                  hund_evt;
  logic                  tick_wrap;
  logic                  wake_wrap;
  logic                  exit_evt;
  logic                  asleep;

  // Sub-ticks per base period divided by multiplier; non-divisors fall back to STEP_MAX
  function automatic logic [7:0] step_of(input logic [7:0] mult);
    logic [7:0] s;
    s = tick_rate_pkg::STEP_MAX;
    case (mult)
      8'h01:   s = 8'hC8;
      8'h02:   s = 8'h64;
      8'h04:   s = 8'h32;
      8'h05:   s = 8'h28;
      8'h08:   s = 8'h19;
      8'h0A:   s = 8'h14;
      8'h14:   s = 8'h0A;
      8'h19:   s = 8'h08;
      8'h28:   s = 8'h05;
      8'h32:   s = 8'h04;
      8'h64:   s = 8'h02;
      8'hC8:   s = 8'h01;
      // 64 and 192 need the faster crystal of other variants
      default: s = tick_rate_pkg::STEP_MAX;
    endcase
    return s;
  endfunction

  assign asleep   = (state_ff != tick_rate_pkg::ST_RUN);
  assign hund_evt = sub_wrap && phase_wrap;
  // Spacing level on the receive line at the minute check
  assign exit_evt = (state_ff == tick_rate_pkg::ST_CHECK) && rx_line;

  // One shared chain: cycles to sub-ticks, sub-ticks to 10 ms
  mod_counter #(.WIDTH(11)) u_prescale (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (1'b0),
    .en       (1'b1),
    .limit    (PRESCALE),
    .count    (),
    .wrap     (sub_wrap)
  );

  mod_counter #(.WIDTH(8)) u_phase (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (1'b0),
    .en       (sub_wrap),
    .limit    (tick_rate_pkg::STEP_MAX),
    .count    (),
    .wrap     (phase_wrap)
  );

  // Realigns to the 10 ms boundary so ticks stay locked to hundredths
  mod_counter #(.WIDTH(8)) u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (wait_restart || hund_evt),
    .en       (sub_wrap),
    .limit    (step_ff),
    .count    (),
    .wrap     (tick_wrap)
  );

  mod_counter #(.WIDTH(13)) u_wake (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (!asleep),
    .en       ((state_ff == tick_rate_pkg::ST_DORMANT) && hund_evt),
    .limit    (WAKE_HUND),
    .count    (),
    .wrap     (wake_wrap)
  );

  // Power state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tick_rate_pkg::ST_RUN: begin
        if (dormant_entry_command) begin
          nxt_state = tick_rate_pkg::ST_DORMANT;
        end
      end
      tick_rate_pkg::ST_DORMANT: begin
        // Nothing but the minute wake leaves here; reset aside
        if (wake_wrap) begin
          nxt_state = tick_rate_pkg::ST_CHECK;
        end
      end
      tick_rate_pkg::ST_CHECK: begin
        if (exit_evt) begin
          nxt_state = tick_rate_pkg::ST_RUN;
        end else begin
          nxt_state = tick_rate_pkg::ST_DORMANT;
        end
      end
      default: nxt_state = tick_rate_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= tick_rate_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Multiplier, active step and hundredths
  always_comb begin
    nxt_rate = rate_ff;
    nxt_step = step_ff;
    nxt_hund = hund_ff;
    if (hund_evt) begin
      nxt_hund = hund_ff + HUND_WIDTH'(1);
    end
    if (exit_evt) begin
      nxt_rate = tick_rate_pkg::RATE_RST;
      nxt_step = step_of(tick_rate_pkg::RATE_RST);
      nxt_hund = tick_rate_pkg::HUND_RST[HUND_WIDTH-1:0];
    end else if (!asleep) begin
      if (rate_wr) begin
        nxt_rate = rate_val;
      end
      // New multiplier only applies once the wait timer restarts
      if (wait_restart) begin
        nxt_step = step_of(rate_ff);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rate_ff <= tick_rate_pkg::RATE_RST;
      step_ff <= tick_rate_pkg::STEP_MAX;
      hund_ff <= '0;
    end else begin
      rate_ff <= nxt_rate;
      step_ff <= nxt_step;
      hund_ff <= nxt_hund;
    end
  end

  // Status outputs, interrupt and supply selection
  always_comb begin
    // The hundredth clear masks a coinciding wrap,
    // so the boundary raises the tick itself
    // Ticks stop while dormant; nothing runs to serve them
    nxt_hk_irq     = (tick_wrap || hund_evt) && !asleep;
    nxt_dormant    = (nxt_state != tick_rate_pkg::ST_RUN);
    nxt_check      = (nxt_state == tick_rate_pkg::ST_CHECK);
    nxt_abort      = exit_evt;
    // Option only matters while running
    nxt_supply_low = nxt_dormant ? 1'b1 : low_voltage_option;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hk_irq_ff     <= 1'b0;
      dormant_ff    <= 1'b0;
      check_ff      <= 1'b0;
      abort_ff      <= 1'b0;
      supply_low_ff <= 1'b0;
    end else begin
      hk_irq_ff     <= nxt_hk_irq;
      dormant_ff    <= nxt_dormant;
      check_ff      <= nxt_check;
      abort_ff      <= nxt_abort;
      supply_low_ff <= nxt_supply_low;
    end
  end

  // I/O state is kept untouched through dormancy, only the drive is cut
  always_comb begin
    nxt_io_dir = io_dir_ff;
    nxt_io_lvl = io_lvl_ff;
    if (io_wr && !asleep) begin
      nxt_io_dir = io_dir_val;
      nxt_io_lvl = io_lvl_val;
    end
    if (nxt_state != tick_rate_pkg::ST_RUN) begin
      nxt_gpio_oe = '0;
      nxt_gpio_o  = '0;
    end else begin
      nxt_gpio_oe = nxt_io_dir;
      nxt_gpio_o  = nxt_io_lvl & nxt_io_dir;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      io_dir_ff  <= '0;
      io_lvl_ff  <= '0;
      gpio_oe_ff <= '0;
      gpio_o_ff  <= '0;
    end else begin
      io_dir_ff  <= nxt_io_dir;
      io_lvl_ff  <= nxt_io_lvl;
      gpio_oe_ff <= nxt_gpio_oe;
      gpio_o_ff  <= nxt_gpio_o;
    end
  end

endmodule // tick_rate_and_dormant_wake
`default_nettype wire

// ===== test/tick_rate_sva.sv
// Port assertions for the tick and dormant logic.
// Bound to the top module from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module tick_rate_sva #(
  parameter int unsigned IO_LINES   = 16,
  parameter int unsigned HUND_WIDTH = 32
) (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire logic                  dormant_entry_command,
  input wire logic                  rx_line,
  input wire logic                  hk_irq_ff,
  input wire logic [HUND_WIDTH-1:0] hund_ff,
  input wire logic [7:0]            rate_ff,
  input wire logic                  dormant_ff,
  input wire logic                  check_ff,
  input wire logic                  abort_ff,
  input wire logic                  supply_low_ff,
  input wire logic [IO_LINES-1:0]   gpio_oe_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_entry_taken:
    assert property (dormant_entry_command && !dormant_ff |=> dormant_ff)
    else $error("entry not taken");
  chk_dormant_quiet:
    assert property (dormant_ff |-> gpio_oe_ff == '0 && supply_low_ff)
    else $error("pins driven or supply high while dormant");
  chk_break_exit:
    assert property (check_ff && rx_line |=> abort_ff && !dormant_ff && rate_ff == 8'h01
      && hund_ff == '0)
    else $error("break exit wrong");
  chk_no_break:
    assert property (check_ff && !rx_line |=> dormant_ff && !abort_ff)
    else $error("left dormancy without break");
  chk_check_pulse:
    assert property (check_ff |-> dormant_ff ##1 !check_ff)
    else $error("check pulse wrong");
  chk_exit_cause:
    assert property ($fell(dormant_ff) |-> abort_ff)
    else $error("dormancy ended without break");
  chk_rate_frozen:
    assert property (dormant_ff && !check_ff |=> $stable(rate_ff))
    else $error("rate changed while dormant");
  chk_hund_step:
    assert property ($changed(hund_ff) |-> hund_ff == $past(hund_ff) + 1'b1 || abort_ff)
    else $error("hundredths jumped");
  chk_hund_tick:
    assert property ($changed(hund_ff) && !dormant_ff && !abort_ff |-> hk_irq_ff)
    else $error("hundredth without tick");
endmodule // tick_rate_sva
`default_nettype wire

// ===== test/tick_rate_and_dormant_wake_tb_top.sv
// Self-checking bench for the tick and dormant logic.
// Short prescale and wake counts; bench drives every port.
`timescale 1ns/10ps
`default_nettype none
module tick_rate_and_dormant_wake_tb_top;
  localparam int PS = 4;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        rate_wr = 1'b0;
  logic [7:0]  rate_val = 8'h00;
  logic        wait_restart = 1'b0;
  logic        dormant_entry_command = 1'b0;
  logic        low_voltage_option = 1'b0;
  logic        rx_line = 1'b0;
  logic        io_wr = 1'b0;
  logic [15:0] io_dir_val = 16'h0000;
  logic [15:0] io_lvl_val = 16'h0000;
  logic        hk_irq_ff, dormant_ff, check_ff, abort_ff, supply_low_ff;
  logic [31:0] hund_ff;
  logic [7:0]  rate_ff;
  logic [15:0] gpio_o_ff, gpio_oe_ff;
  int          errors = 0;
  int          tests_run = 0;
  int          n;

  tick_rate_and_dormant_wake #(.PRESCALE(11'h004), .WAKE_HUND(13'h0003)) i_dut (
    .core_clk              (core_clk),
    .nrst                  (nrst),
    .rate_wr               (rate_wr),
    .rate_val              (rate_val),
    .wait_restart          (wait_restart),
    .dormant_entry_command (dormant_entry_command),
    .low_voltage_option    (low_voltage_option),
    .rx_line               (rx_line),
    .io_wr                 (io_wr),
    .io_dir_val            (io_dir_val),
    .io_lvl_val            (io_lvl_val),
    .hk_irq_ff             (hk_irq_ff),
    .hund_ff               (hund_ff),
    .rate_ff               (rate_ff),
    .dormant_ff            (dormant_ff),
    .check_ff              (check_ff),
    .abort_ff              (abort_ff),
    .supply_low_ff         (supply_low_ff),
    .gpio_o_ff             (gpio_o_ff),
    .gpio_oe_ff            (gpio_oe_ff)
  );

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Bounded wait: 0 tick, 1 minute check, 2 hundredth change
  task automatic wait_ev(input int k, output int c);
    logic [31:0] h;
    h = hund_ff;
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (c < 4000 && (k == 0 ? hk_irq_ff : k == 1 ? check_ff : hund_ff != h) !== 1'b1);
  endtask

  task automatic set_rate(input logic [7:0] m, input logic rs);
    @(posedge core_clk) rate_wr <= 1'b1;
    rate_val <= m;
    @(posedge core_clk) rate_wr <= 1'b0;
    wait_restart <= rs;
    @(posedge core_clk) wait_restart <= 1'b0;
  endtask

  // Third tick measured: first period after restart may be short
  task automatic t_rate(input logic [7:0] m, input logic rs, input int step);
    set_rate(m, rs);
    repeat (3) wait_ev(0, n);
    chk(n, PS * step);
    chk(rate_ff, m);
  endtask

  task automatic t_reset();
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({rate_ff, hund_ff[23:0]}, 32'h0100_0000);
    $display("reset test done");
  endtask

  task automatic t_rates();
    logic [7:0] v[12] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0A,
                          8'h14, 8'h19, 8'h28, 8'h32, 8'h64, 8'hC8};
    t_rate(8'h04, 1'b0, 200);
    foreach (v[i]) t_rate(v[i], 1'b1, 200 / v[i]);
    t_rate(8'h03, 1'b1, 200);
    t_rate(8'hC0, 1'b1, 200);
    $display("rate test done");
  endtask

  task automatic t_hund();
    repeat (2) wait_ev(2, n);
    chk(n, PS * 200);
    $display("hundredths test done");
  endtask

  task automatic t_dormant();
    @(posedge core_clk) io_wr <= 1'b1;
    io_dir_val <= 16'hA5C3;
    io_lvl_val <= 16'hFF0F;
    @(posedge core_clk) io_wr <= 1'b0;
    set_rate(8'h0A, 1'b1);
    @(posedge core_clk) dormant_entry_command <= 1'b1;
    low_voltage_option <= 1'b1;
    @(posedge core_clk) dormant_entry_command <= 1'b0;
    rate_wr <= 1'b1;
    rate_val <= 8'h32;
    io_wr <= 1'b1;
    io_dir_val <= 16'hFFFF;
    @(posedge core_clk) rate_wr <= 1'b0;
    io_wr <= 1'b0;
    @(negedge core_clk);
    chk({dormant_ff, supply_low_ff, gpio_oe_ff}, 32'h0003_0000);
    chk(gpio_o_ff, 32'h0000_0000);
    wait_ev(1, n);
    @(negedge core_clk);
    chk({dormant_ff, abort_ff, rate_ff}, 32'h0000_020A);
    @(posedge core_clk) rx_line <= 1'b1;
    wait_ev(1, n);
    @(negedge core_clk);
    chk({abort_ff, dormant_ff, supply_low_ff, rate_ff, hund_ff[15:0]}, 32'h0501_0000);
    chk({gpio_oe_ff, gpio_o_ff}, 32'hA5C3_A503);
    @(posedge core_clk) rx_line <= 1'b0;
    low_voltage_option <= 1'b0;
    $display("dormant test done");
  endtask

  initial begin
    t_reset();
    t_rates();
    t_hund();
    t_dormant();
    set_rate(8'h08, 1'b1);
    t_reset();
    stop_test();
  end

  // Whole run needs about 18400 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    stop_test();
  end
endmodule // tick_rate_and_dormant_wake_tb_top

bind tick_rate_and_dormant_wake tick_rate_sva #(.IO_LINES(IO_LINES),
  .HUND_WIDTH(HUND_WIDTH)) i_sva (.*);
`default_nettype wire
